/* inc/dscd_map.vh */
`ifndef DSCD_MAP_VH
`define DSCD_MAP_VH
`define DSCD_WORD_BITS 24
`define DSCD_FRAME_EDGES 5'h18
`define DSCD_RW_BIT 23
`define DSCD_ZERO_BIT 22
`define DSCD_REG_HI 21
`define DSCD_REG_LO 19
`define DSCD_CH_HI 18
`define DSCD_CH_LO 16
`define DSCD_REG_FUNC 3'h0
`define DSCD_REG_DATA 3'h2
`define DSCD_REG_CGAIN 3'h3
`define DSCD_REG_FGAIN 3'h4
`define DSCD_CH_ALL 3'h4
`define DSCD_OP_NOP 3'h0
`define DSCD_OP_CTRL 3'h1
`define DSCD_OP_CLEAR 3'h4
`define DSCD_OP_LOAD 3'h5
`define DSCD_CTL_GOFS 5
`define DSCD_CTL_P1_DIR 4
`define DSCD_CTL_P1_VAL 3
`define DSCD_CTL_P0_DIR 2
`define DSCD_CTL_P0_VAL 1
`define DSCD_CTL_RB_DIS 0
`define DSCD_CTL_RESET 6'h00
`define DSCD_CODE_HI 15
`define DSCD_CODE_LO 2
`define DSCD_CLEAR_TWOS 14'h0000
`define DSCD_CLEAR_BIN 14'h0000
`endif

/* test/dscd_decoder_bench.sv */
module dscd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ld_n = 1'b1;
  logic twos = 1'b1;
  logic ext0 = 1'b0;
  logic ext1 = 1'b1;
  logic [23:0] rb;
  logic [55:0] ab = {28'h0, 14'h048D, 14'h2AF3};
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_rbe = 0;
  int rbe_mark = 0;
  wire sclk, sync_n, sdi, o0, e0, o1, e1, rbo, rbe, gofs;
  wire [55:0] codes;
  wire [7:0] cg;
  wire [23:0] fg;
  wire pin0 = e0 ? o0 : ext0;
  wire pin1 = e1 ? o1 : ext1;
  // A disabled readback line must not keep showing the last bit.
  wire rb_line = rbe ? rbo : ~rbo;
  dscd_decoder DUT (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .sync_n(sync_n), .serial_command_input(sdi),
    .load_strobe_n(ld_n), .clear_twos_complement(twos), .gpio_pin_zero_in(pin0), .gpio_pin_one_in(pin1),
    .gpio_pin_zero_out(o0), .gpio_pin_zero_oe(e0), .gpio_pin_one_out(o1), .gpio_pin_one_oe(e1),
    .serial_readback_output(rbo), .serial_readback_oe(rbe), .ground_offset_enable(gofs),
    .dac_active_codes(codes), .coarse_gains(cg), .fine_gains(fg));
  dscd_host host (.mclk(mclk), .serial_readback_output(rb_line), .sclk(sclk), .sync_n(sync_n),
    .serial_command_input(sdi));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rbe) n_rbe <= n_rbe + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [23:0] w, input int n = 24);
    host.frame(w, n, rb);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    cmd(24'h010034);
    chk({gofs, e1, o1, e0, o0}, 5'h1A);
    cmd(24'h010026);
    chk({gofs, e1, o1, e0, o0}, 5'h13);
    cmd(24'h800000);
    rbe_mark = n_rbe;
    cmd(24'h000000);
    chk(rb, 24'h80002E);
    chk(n_rbe != rbe_mark, 1'b1);
    chk({gofs, e1, o1, e0, o0}, 5'h13);
    cmd(24'h10ABCF);
    chk(codes, 56'h0);
    ld_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(codes, 56'h2AF3);
    cmd(24'h111234);
    chk(codes, ab);
    ld_n <= 1'b1;
    cmd(24'h120004);
    chk(codes, ab);
    cmd(24'h050000);
    chk(codes, {14'h0, 14'h0001, ab[27:0]});
    twos <= 1'b0;
    cmd(24'h040000);
    chk(codes, 56'h0);
    cmd(24'h180002);
    cmd(24'h240021);
    chk({cg, fg}, {8'h02, {4{6'h21}}});
    cmd(24'h1C0001);
    chk(cg, 8'h55);
    cmd(24'h1C0003, 23);
    cmd(24'h1C0003, 25);
    cmd(24'h5C0003);
    cmd(24'h0C0003);
    cmd(24'h030000);
    chk({cg, gofs, e1, e0}, {8'h55, 3'h5});
    cmd(24'h980000);
    cmd(24'h000000);
    chk(rb, 24'h980001);
    cmd(24'h01002F);
    chk({gofs, e1, o1, e0, o0}, 5'h13);
    rbe_mark = n_rbe;
    cmd(24'h000000);
    chk(n_rbe == rbe_mark, 1'b1);
    final_report();
  end
endmodule // dscd_decoder_bench

/* test/dscd_decoder_chk.sv */
module dscd_chk (
  input wire mclk,
  input wire reset_n,
  input wire sync_n,
  input wire load_strobe_n,
  input wire serial_readback_oe,
  input wire ground_offset_enable,
  input wire gpio_pin_zero_oe,
  input wire gpio_pin_one_oe,
  input wire [55:0] dac_active_codes,
  input wire [7:0] coarse_gains,
  input wire [23:0] fine_gains
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire [2:0] ctl = {ground_offset_enable, gpio_pin_zero_oe, gpio_pin_one_oe};
  property p_rst; $rose(reset_n) |-> dac_active_codes == 56'h0 && ctl == 3'h0; endproperty
  property p_rb_idle; sync_n [*4] |-> !serial_readback_oe; endproperty
  property p_gain_frm; !sync_n [*8] |-> $stable({coarse_gains, fine_gains}); endproperty
  property p_ctl_frm; !sync_n [*8] |-> $stable(ctl); endproperty
  property p_dac_frm; (!sync_n && load_strobe_n) [*8] |-> $stable(dac_active_codes); endproperty
  property p_dac_idle; (sync_n && load_strobe_n) [*8] |-> $stable(dac_active_codes); endproperty
  property p_gain_idle; sync_n [*8] |-> $stable({coarse_gains, fine_gains, ctl}); endproperty
  property p_dac_ld; (sync_n && !load_strobe_n) [*8] |-> $stable(dac_active_codes); endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_rb_idle: assert property (p_rb_idle) else $error("readback on idle");
  a_gain_frm: assert property (p_gain_frm) else $error("gain moved in frame");
  a_ctl_frm: assert property (p_ctl_frm) else $error("control moved in frame");
  a_dac_frm: assert property (p_dac_frm) else $error("code moved in frame");
  a_dac_idle: assert property (p_dac_idle) else $error("code moved idle");
  a_gain_idle: assert property (p_gain_idle) else $error("state moved idle");
  a_dac_ld: assert property (p_dac_ld) else $error("code moved late");
  c_ctl: cover property ($rose(ground_offset_enable));
  c_ld: cover property ($fell(load_strobe_n));
  c_rb: cover property ($rose(serial_readback_oe));
endmodule // dscd_chk
bind dscd_decoder dscd_chk u_chk (.mclk(mclk), .reset_n(reset_n), .sync_n(sync_n), .load_strobe_n(load_strobe_n),
  .serial_readback_oe(serial_readback_oe), .ground_offset_enable(ground_offset_enable),
  .gpio_pin_zero_oe(gpio_pin_zero_oe), .gpio_pin_one_oe(gpio_pin_one_oe), .dac_active_codes(dac_active_codes),
  .coarse_gains(coarse_gains), .fine_gains(fine_gains));

/* test/dscd_host.sv */
module dscd_host (
  input wire mclk,
  input wire serial_readback_output,
  output logic sclk,
  output logic sync_n,
  output logic serial_command_input
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sclk, sync_n, serial_command_input} = 3'h6;
  // A count other than 24 is only used to provoke a discarded frame.
  task automatic frame(input logic [23:0] w, input int n, output logic [23:0] rb);
    rb = 24'h0;
    sync_n <= 1'b0;
    serial_command_input <= w[23];
    repeat (4) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      repeat (3) @(posedge mclk);
      rb = {rb[22:0], serial_readback_output};
      @(posedge mclk);
      sclk <= 1'b1;
      serial_command_input <= w[(46 - i) % 24];
      repeat (4) @(posedge mclk);
    end
    sync_n <= 1'b1;
    // The released data line must not keep showing the last bit.
    serial_command_input <= ~serial_command_input;
    repeat (12) @(posedge mclk);
  endtask
endmodule // dscd_host

/* verilog/dscd_decoder.v */
// Functional notes
// - Word is 24 bits MSB first: rw, zero, register, channel, 16 data bits.
// - Read flag one reads the selected register; zero writes data into it.
// - Register select: 000 function, 010 data, 011 coarse gain, 100 fine gain.
// - Channel select: 000..011 channels A..D, 100 all four channels.
// - Function operation from channel bits: 000 nop, 001 control, 100 clear, 101 load.
// - No-operation changes no state; used as filler while readback shifts out.
// - Control bits 5..0: offset adjust, pin1 dir/val, pin0 dir/val, readback disable.
// - Offset adjust bit enables ground offset compensation; resets disabled.
// - Direction one makes pin an output; reset leaves pins as inputs.
// - Output pin drives last written value bit.
// - Input pin value bit reports live level; writes to it ignored.
// - Readback disable bit turns readback output off; reset has it enabled.
// - Software clear forces all channel outputs to the clear code.
// - Software load copies all pending input values to active registers.
// - After a read, register contents shift out during the next frame.
// - Load low in frame updates addressed channel at frame end, else on load fall.
// - Data write takes the 14-bit code from bits 15..2.
`include "dscd_map.vh"
module dscd_decoder (
  input wire mclk,
  input wire reset_n,
  input wire sclk,
  input wire sync_n,
  input wire serial_command_input,
  input wire load_strobe_n,
  input wire clear_twos_complement,
  input wire gpio_pin_zero_in,
  input wire gpio_pin_one_in,
  output reg gpio_pin_zero_out,
  output reg gpio_pin_zero_oe,
  output reg gpio_pin_one_out,
  output reg gpio_pin_one_oe,
  output reg serial_readback_output,
  output reg serial_readback_oe,
  output reg ground_offset_enable,
  output reg [55:0] dac_active_codes,
  output reg [7:0] coarse_gains,
  output reg [23:0] fine_gains
);
  wire [4:0] sync_v;
  reg sclk_q, sync_q;
  reg [23:0] shift_q;
  reg [4:0] count_q;
  reg over_q;
  reg [23:0] rb_q;
  reg [5:0] ctl_q;
  reg [13:0] pend_q [0:3];
  reg [13:0] act_q [0:3];
  reg [1:0] cg_q [0:3];
  reg [5:0] fg_q [0:3];
  integer i;
  // Data passes two stages like the link clock, so each bit is read at the fall it belongs to.
  reg sdi_m_q, sdi_s_q;

  dscd_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({gpio_pin_one_in, gpio_pin_zero_in, load_strobe_n, sync_n, sclk}),
    .sync_out(sync_v)
  );

  wire sclk_s = sync_v[0];
  wire sync_s = sync_v[1];
  wire load_strobe_n_s = sync_v[2];
  wire p0_s = sync_v[3];
  wire p1_s = sync_v[4];
  reg load_strobe_n_q;
  wire sclk_fall = sclk_q & ~sclk_s;
  wire sclk_rise = ~sclk_q & sclk_s;
  wire frame_end = ~sync_q & sync_s;
  wire frame_start = sync_q & ~sync_s;
  wire load_strobe_n_fall = load_strobe_n_q & ~load_strobe_n_s;
  wire [23:0] word = shift_q;
  wire [2:0] reg_sel = word[`DSCD_REG_HI:`DSCD_REG_LO];
  wire [2:0] ch_sel = word[`DSCD_CH_HI:`DSCD_CH_LO];
  wire word_ok = (count_q == `DSCD_FRAME_EDGES) & ~over_q & ~word[`DSCD_ZERO_BIT];
  // Both clear codes are all zeros: zero volts in twos complement, bottom of scale in offset binary.
  wire [13:0] clr_code = clear_twos_complement ? `DSCD_CLEAR_TWOS : `DSCD_CLEAR_BIN;

  // Function readback merges live levels for pins that are inputs.
  function [5:0] ctl_view;
    input [5:0] c;
    input l0, l1;
    begin
      ctl_view = c;
      if (!c[`DSCD_CTL_P0_DIR]) ctl_view[`DSCD_CTL_P0_VAL] = l0;
      if (!c[`DSCD_CTL_P1_DIR]) ctl_view[`DSCD_CTL_P1_VAL] = l1;
    end
  endfunction

  function hits;
    input [2:0] sel;
    input [1:0] ch;
    begin
      // Channel codes above the all-channels code hit nothing, so such writes fall away.
      hits = (sel == `DSCD_CH_ALL) | (sel == {1'b0, ch});
    end
  endfunction

  // A value bit written while its pin stays an input is dropped, so a later switch
  // to output does not drive a level nobody asked for.
  function [5:0] ctl_write;
    input [5:0] old;
    input [5:0] w;
    begin
      ctl_write = w;
      if (!w[`DSCD_CTL_P0_DIR]) ctl_write[`DSCD_CTL_P0_VAL] = old[`DSCD_CTL_P0_VAL];
      if (!w[`DSCD_CTL_P1_DIR]) ctl_write[`DSCD_CTL_P1_VAL] = old[`DSCD_CTL_P1_VAL];
    end
  endfunction

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Edge detectors rest at the idle high level, so reset leaves no false edge behind.
      sclk_q <= 1'b1;
      sync_q <= 1'b1;
      load_strobe_n_q <= 1'b1;
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
      shift_q <= 24'h000000;
      count_q <= 5'h00;
      over_q <= 1'b0;
      rb_q <= 24'h000000;
      ctl_q <= `DSCD_CTL_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        pend_q[i] <= 14'h0000;
        act_q[i] <= 14'h0000;
        cg_q[i] <= 2'h0;
        fg_q[i] <= 6'h00;
      end
    end else begin
      sclk_q <= sclk_s;
      sync_q <= sync_s;
      load_strobe_n_q <= load_strobe_n_s;
      sdi_m_q <= serial_command_input;
      sdi_s_q <= sdi_m_q;
      // A frame cut short or run long is still closed by its end, but word_ok keeps it from landing.
      if (frame_start) begin
        count_q <= 5'h00;
        over_q <= 1'b0;
      end else if (!sync_s && sclk_fall) begin
        shift_q <= {shift_q[22:0], sdi_s_q};
        if (count_q == `DSCD_FRAME_EDGES) over_q <= 1'b1;
        else count_q <= count_q + 5'h01;
      end
      // Readback word moves one bit per rising edge inside a frame once its first falling edge is counted.
      if (!sync_s && sclk_rise && count_q != 5'h00) rb_q <= {rb_q[22:0], 1'b0};
      if (load_strobe_n_fall)
        for (i = 0; i < 4; i = i + 1) act_q[i] <= pend_q[i];
      if (frame_end && word_ok) begin
        if (word[`DSCD_RW_BIT]) begin
          case (reg_sel)
            `DSCD_REG_FUNC: rb_q <= {word[23:16], 10'h000, ctl_view(ctl_q, p0_s, p1_s)};
            `DSCD_REG_DATA: rb_q <= {word[23:16], pend_q[ch_sel[1:0]], 2'h0};
            `DSCD_REG_CGAIN: rb_q <= {word[23:16], 14'h0000, cg_q[ch_sel[1:0]]};
            `DSCD_REG_FGAIN: rb_q <= {word[23:16], 10'h000, fg_q[ch_sel[1:0]]};
            default: rb_q <= rb_q;
          endcase
        end else begin
          case (reg_sel)
            `DSCD_REG_FUNC: begin
              case (ch_sel)
                `DSCD_OP_NOP: ctl_q <= ctl_q;
                `DSCD_OP_CTRL: ctl_q <= ctl_write(ctl_q, word[5:0]);
                `DSCD_OP_CLEAR:
                  for (i = 0; i < 4; i = i + 1) act_q[i] <= clr_code;
                `DSCD_OP_LOAD:
                  for (i = 0; i < 4; i = i + 1) act_q[i] <= pend_q[i];
                default: ctl_q <= ctl_q;
              endcase
            end
            `DSCD_REG_DATA:
              for (i = 0; i < 4; i = i + 1)
                if (hits(ch_sel, i[1:0])) begin
                  pend_q[i] <= word[`DSCD_CODE_HI:`DSCD_CODE_LO];
                  if (!load_strobe_n_s) act_q[i] <= word[`DSCD_CODE_HI:`DSCD_CODE_LO];
                end
            // Gain writes take only their low bits; the rest of the data field is ignored.
            `DSCD_REG_CGAIN:
              for (i = 0; i < 4; i = i + 1)
                if (hits(ch_sel, i[1:0])) cg_q[i] <= word[1:0];
            `DSCD_REG_FGAIN:
              for (i = 0; i < 4; i = i + 1)
                if (hits(ch_sel, i[1:0])) fg_q[i] <= word[5:0];
            default: ctl_q <= ctl_q;
          endcase
        end
      end
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Outputs are registered copies, so the pins never show a decode glitch.
      gpio_pin_zero_out <= 1'b0;
      gpio_pin_zero_oe <= 1'b0;
      gpio_pin_one_out <= 1'b0;
      gpio_pin_one_oe <= 1'b0;
      serial_readback_output <= 1'b0;
      serial_readback_oe <= 1'b0;
      ground_offset_enable <= 1'b0;
      dac_active_codes <= 56'h00000000000000;
      coarse_gains <= 8'h00;
      fine_gains <= 24'h000000;
    end else begin
      gpio_pin_zero_oe <= ctl_q[`DSCD_CTL_P0_DIR];
      gpio_pin_zero_out <= ctl_q[`DSCD_CTL_P0_VAL];
      gpio_pin_one_oe <= ctl_q[`DSCD_CTL_P1_DIR];
      gpio_pin_one_out <= ctl_q[`DSCD_CTL_P1_VAL];
      ground_offset_enable <= ctl_q[`DSCD_CTL_GOFS];
      serial_readback_output <= rb_q[23];
      serial_readback_oe <= ~ctl_q[`DSCD_CTL_RB_DIS] & ~sync_s;
      dac_active_codes <= {act_q[3], act_q[2], act_q[1], act_q[0]};
      coarse_gains <= {cg_q[3], cg_q[2], cg_q[1], cg_q[0]};
      fine_gains <= {fg_q[3], fg_q[2], fg_q[1], fg_q[0]};
    end
  end
endmodule // dscd_decoder

/* verilog/dscd_sync.v */
module dscd_sync (
  input wire mclk,
  input wire reset_n,
  input wire [4:0] async_in,
  output reg [4:0] sync_out
);
  reg [4:0] meta_q;

  // Two stages only; the first stage feeds nothing but the second.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 5'h1F;
      sync_out <= 5'h1F;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // dscd_sync
